// ===== pcl_pkg.sv
// Constants and types shared by the paged configuration loader.
// Assumes one 250 MHz clock and a 16-bit flash word of four nibbles.
`default_nettype none
package pcl_pkg;
    // Page table shape.
    localparam int unsigned PCL_PAGES = 8;
    localparam int unsigned PCL_SEL_W = 3;
    localparam int unsigned PCL_ADDR_W = 23;
    localparam int unsigned PCL_LEN_W = 25;
    localparam int unsigned PCL_WORD_W = 16;
    localparam int unsigned PCL_LINES = 8;
    localparam int unsigned PCL_FIFO_DEPTH = 2;
    // Legal window for a page start word address.
    localparam logic [22:0] PCL_PAGE_MIN = 23'h008020;
    localparam logic [22:0] PCL_PAGE_MAX = 23'h0fffff;
    // Register byte offsets (low 12 address bits).
    localparam logic [11:0] PCL_OFF_CTRL = 12'h000;
    localparam logic [11:0] PCL_OFF_STATUS = 12'h004;
    localparam logic [5:0] PCL_PTR_BLOCK = 6'h01;
    // Control fields.
    localparam int unsigned PCL_CTRL_GO = 0;
    localparam int unsigned PCL_CTRL_MODE_LSB = 1;
    localparam logic [1:0] PCL_MODE_RST = 2'h0;
    // Reset values of the page pointers: blank.
    localparam logic [22:0] PCL_START_RST = 23'h000000;
    localparam logic [24:0] PCL_LEN_RST = 25'h0000000;
    // Target clock timing.
    localparam int unsigned PCL_CLK_NS = 4;
    localparam int unsigned PCL_DCLK_HALF_NS = 10;
    localparam int unsigned PCL_DCLK_HALF_CYC =
        (PCL_DCLK_HALF_NS + PCL_CLK_NS - 1) / PCL_CLK_NS;
    // Loader states.
    typedef enum logic [2:0] {
        PCL_IDLE,
        PCL_SAMPLE,
        PCL_CHECK,
        PCL_RUN,
        PCL_DONE,
        PCL_ERR
    } pcl_state_e;
endpackage
`default_nettype wire

// ===== pcl_paged_config_loader.sv
// Page-selected configuration loader with an AHB-Lite register slave.
// Assumes a flash port that answers each read with one flash_rvalid
// pulse, and target pins that are asynchronous to hclk.
`timescale 1ns/1ps
`default_nettype none

module pcl_paged_config_loader
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic [pcl_pkg::PCL_SEL_W-1:0] page_select_inputs,
    output logic flash_rd,
    output logic [pcl_pkg::PCL_ADDR_W-1:0] flash_addr,
    input wire logic [pcl_pkg::PCL_WORD_W-1:0] flash_rdata,
    input wire logic flash_rvalid,
    output logic target_dclk,
    output logic [pcl_pkg::PCL_LINES-1:0] target_data,
    output logic target_data_en,
    output logic target_reconfig_request_n,
    input wire logic target_load_complete,
    input wire logic target_error_line_n
);
    import pcl_pkg::*;

    pcl_state_e st_q; // Loader state.
    logic [2:0] pg_s1_q, pg_s2_q, pg_s3_q, pg_q; // Select pin filter.
    logic [1:0] ln_s1_q, ln_s2_q, ln_s3_q, ln_q; // Target line filter.
    logic [2:0] page_q; // Page latched for this load.
    logic [22:0] start_q [PCL_PAGES]; // Page start word addresses.
    logic [24:0] len_q [PCL_PAGES]; // Page lengths in nibbles.
    logic [1:0] mode_q; // Data line count, log2.
    logic go_q; // Software start pulse.
    logic wr_q; // A write data phase is due.
    logic [11:0] wa_q; // Address held for that write.
    logic [31:0] hrdata_q, rd_val;
    logic hreadyout_q;
    logic [22:0] fa_q; // Next flash word address.
    logic [23:0] words_q; // Flash words still to fetch.
    logic pend_q, rd_q; // Read outstanding, read strobe.
    logic [15:0] mem_q [PCL_FIFO_DEPTH]; // Two-entry word buffer.
    logic wp_q, rp_q; // Buffer pointers.
    logic [1:0] cnt_q; // Buffer fill.
    logic [1:0] div_q; // Half-period divider.
    logic tick_q; // One-cycle half-period enable.
    logic dclk_q, en_q;
    logic [7:0] data_q;
    logic [15:0] sreg_q; // Word being shifted out.
    logic [4:0] sbits_q; // Bits left in sreg_q.
    logic [26:0] bits_q; // Bits of the page left to send.
    logic rcfg_n_q;

    wire acc = hsel && htrans[1] && hready;
    wire [22:0] sel_start = start_q[page_q];
    wire [24:0] sel_len = len_q[page_q];
    wire [25:0] len_rnd = {1'b0, sel_len} + 26'h0000003;
    wire page_ok = (sel_len != 25'h0000000) &&
        (sel_start >= PCL_PAGE_MIN) && (sel_start <= PCL_PAGE_MAX);
    wire [3:0] w = 4'h1 << mode_q; // Active data lines.
    wire [7:0] lane_mask = 8'((9'h001 << w) - 9'h001);
    wire push = flash_rvalid && pend_q;
    wire fall = tick_q && dclk_q && (st_q == PCL_RUN);
    wire last = fall && (bits_q == 27'h0000000);
    wire need = fall && !last && (sbits_q == 5'h00);
    wire pop = need && (cnt_q != 2'h0);
    wire step = fall && !last && (sbits_q != 5'h00 || cnt_q != 2'h0);
    wire [15:0] src = (sbits_q == 5'h00) ? mem_q[rp_q] : sreg_q;

    // Pins from the board pass three flops; a change counts once the
    // last two agree, so a glitch on a select pin cannot pick a page.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pg_s1_q <= 3'h0;
            pg_s2_q <= 3'h0;
            pg_s3_q <= 3'h0;
            pg_q <= 3'h0;
            ln_s1_q <= 2'h0;
            ln_s2_q <= 2'h0;
            ln_s3_q <= 2'h0;
            ln_q <= 2'h0;
        end
        else
        begin
            pg_s1_q <= page_select_inputs;
            pg_s2_q <= pg_s1_q;
            pg_s3_q <= pg_s2_q;
            ln_s1_q <= {target_load_complete, target_error_line_n};
            ln_s2_q <= ln_s1_q;
            ln_s3_q <= ln_s2_q;
            // Take the value only when the last two stages agree.
            if (pg_s2_q == pg_s3_q)
            begin
                pg_q <= pg_s3_q;
            end
            if (ln_s2_q == ln_s3_q)
            begin
                ln_q <= ln_s3_q;
            end
        end
    end

    // Read mux: ctrl, status, then eight start/length pairs.
    always_comb
    begin
        rd_val = 32'h00000000;
        if (haddr[11:0] == PCL_OFF_CTRL)
        begin
            rd_val = {29'h0, mode_q, 1'b0};
        end
        else if (haddr[11:0] == PCL_OFF_STATUS)
        begin
            rd_val = {21'h0, ln_q, page_q, st_q == PCL_RUN,
                st_q == PCL_DONE, st_q == PCL_ERR, 3'(st_q)};
        end
        else if (haddr[11:6] == PCL_PTR_BLOCK)
        begin
            // Unmapped offsets fall through and read as zero.
            rd_val = haddr[2] ? {7'h0, len_q[haddr[5:3]]}
                : {9'h0, start_q[haddr[5:3]]};
        end
    end

    // Zero-wait slave: read data is caught at the address phase so it
    // stands in the data phase; every answer is OKAY.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata_q <= 32'h00000000;
            hreadyout_q <= 1'b1;
            wr_q <= 1'b0;
            wa_q <= 12'h000;
        end
        else
        begin
            hreadyout_q <= 1'b1;
            wr_q <= acc && hwrite;
            if (acc)
            begin
                wa_q <= haddr[11:0];
            end
            if (acc && !hwrite)
            begin
                hrdata_q <= rd_val;
            end
        end
    end

    // Control register; the start bit is a self-clearing pulse.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            mode_q <= PCL_MODE_RST;
            go_q <= 1'b0;
        end
        else
        begin
            go_q <= wr_q && (wa_q == PCL_OFF_CTRL) && hwdata[PCL_CTRL_GO];
            if (wr_q && wa_q == PCL_OFF_CTRL)
            begin
                mode_q <= hwdata[PCL_CTRL_MODE_LSB +: 2];
            end
        end
    end

    // One start and one length register per page.
    for (genvar i = 0; i < PCL_PAGES; i++)
    begin : g_ptr
        always_ff @(posedge hclk or negedge hresetn)
        begin
            if (!hresetn)
            begin
                start_q[i] <= PCL_START_RST;
                len_q[i] <= PCL_LEN_RST;
            end
            else if (wr_q && wa_q[11:6] == PCL_PTR_BLOCK
                && wa_q[5:3] == 3'(i))
            begin
                // Pointer pair per page.
                if (wa_q[2])
                begin
                    len_q[i] <= hwdata[24:0];
                end
                else
                begin
                    start_q[i] <= hwdata[22:0];
                end
            end
        end
    end

    // Loader sequence. The error state has no way out but reset, so a
    // bad select cannot be retried by software.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st_q <= PCL_IDLE;
        end
        else
        begin
            unique case (st_q)
                PCL_IDLE, PCL_DONE:
                begin
                    if (go_q)
                    begin
                        st_q <= PCL_SAMPLE;
                    end
                end
                PCL_SAMPLE:
                begin
                    st_q <= PCL_CHECK;
                end
                PCL_CHECK:
                begin
                    // Blank or out-of-window page.
                    st_q <= page_ok ? PCL_RUN : PCL_ERR;
                end
                PCL_RUN:
                begin
                    if (last)
                    begin
                        st_q <= PCL_DONE;
                    end
                end
                PCL_ERR:
                begin
                    st_q <= PCL_ERR;
                end
            endcase
        end
    end

    // The page is latched once; the pins are then ignored.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            page_q <= 3'h0;
            rcfg_n_q <= 1'b1;
        end
        else
        begin
            rcfg_n_q <= (st_q != PCL_SAMPLE);
            if (st_q == PCL_SAMPLE)
            begin
                page_q <= pg_q;
            end
        end
    end

    // Fetch: consecutive words from the page start, only while the
    // buffer has room for the answer. The address steps on the answer,
    // so flash_addr names the word in flight for the whole read.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            fa_q <= 23'h000000;
            words_q <= 24'h000000;
            pend_q <= 1'b0;
            rd_q <= 1'b0;
        end
        else
        begin
            rd_q <= 1'b0;
            if (push)
            begin
                pend_q <= 1'b0;
                fa_q <= fa_q + 23'h000001;
            end
            if (st_q == PCL_CHECK && page_ok)
            begin
                fa_q <= sel_start;
                words_q <= len_rnd[25:2];
            end
            else if (st_q == PCL_RUN && words_q != 24'h000000 &&
                !pend_q && cnt_q != 2'h2)
            begin
                rd_q <= 1'b1;
                pend_q <= 1'b1;
                words_q <= words_q - 24'h000001;
            end
        end
    end

    // Buffer storage has no reset: a word is only read after it was
    // written, and leaving reset off keeps the data flops plain.
    always_ff @(posedge hclk)
    begin
        if (push)
        begin
            mem_q[wp_q] <= flash_rdata;
        end
    end

    // Two-entry buffer; a target-side stall stops fetching, not data.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wp_q <= 1'b0;
            rp_q <= 1'b0;
            cnt_q <= 2'h0;
        end
        else
        begin
            if (push)
            begin
                wp_q <= !wp_q;
            end
            if (pop)
            begin
                rp_q <= !rp_q;
            end
            cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
        end
    end

    // Divider for the target clock half period.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            div_q <= 2'h0;
            tick_q <= 1'b0;
        end
        else
        begin
            tick_q <= (div_q == 2'(PCL_DCLK_HALF_CYC - 1));
            div_q <= tick_q ? 2'h1 : div_q + 2'h1;
        end
    end

    // Shifter: data change on the falling edge, targets take it on the
    // rising one. An empty buffer and shift register hold the clock high.
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            dclk_q <= 1'b1;
            en_q <= 1'b0;
            data_q <= 8'h00;
            sreg_q <= 16'h0000;
            sbits_q <= 5'h00;
            bits_q <= 27'h0000000;
        end
        else
        begin
            if (st_q == PCL_CHECK)
            begin
                bits_q <= {sel_len, 2'h0};
                sbits_q <= 5'h00;
            end
            else if (last)
            begin
                en_q <= 1'b0;
                data_q <= 8'h00;
            end
            else if (step)
            begin
                dclk_q <= 1'b0;
                en_q <= 1'b1;
                data_q <= src[7:0] & lane_mask;
                sreg_q <= src >> w;
                sbits_q <= ((sbits_q == 5'h00) ? 5'h10 : sbits_q)
                    - {1'b0, w};
                bits_q <= (bits_q > 27'(w)) ? bits_q - 27'(w)
                    : 27'h0000000;
            end
            else if (tick_q && !dclk_q)
            begin
                dclk_q <= 1'b1;
            end
        end
    end

    assign hrdata = hrdata_q;
    assign hreadyout = hreadyout_q;
    assign hresp = 1'b0;
    assign flash_rd = rd_q;
    assign flash_addr = fa_q;
    assign target_dclk = dclk_q;
    assign target_data = data_q;
    assign target_data_en = en_q;
    assign target_reconfig_request_n = rcfg_n_q;

    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);

    err_sticky_a: assert property (
        st_q == PCL_ERR |=> (st_q == PCL_ERR) [*8])
        else $error("Error state was left.");
    page_hold_a: assert property (
        st_q == PCL_RUN && $past(st_q) == PCL_RUN |-> $stable(page_q))
        else $error("Page changed during a load.");
    page_take_a: assert property (
        st_q == PCL_SAMPLE |=> page_q == $past(pg_q))
        else $error("Page not taken from the select pins.");
    bad_page_a: assert property (
        st_q == PCL_CHECK && sel_len == 25'h0000000 |=> st_q == PCL_ERR)
        else $error("Blank page did not raise error.");
    first_addr_a: assert property (
        st_q == PCL_CHECK && page_ok |=> ##[1:3] rd_q &&
        flash_addr == $past(sel_start, 1))
        else $error("Fetch did not start at page start.");
    window_a: assert property (
        $rose(st_q == PCL_RUN) |-> sel_start >= PCL_PAGE_MIN &&
        sel_start <= PCL_PAGE_MAX)
        else $error("Load began outside the page window.");
    stop_drive_a: assert property (
        st_q == PCL_DONE |-> !en_q && data_q == 8'h00)
        else $error("Data still driven after the page.");
    lane_use_a: assert property (
        en_q |-> (data_q & ~lane_mask) == 8'h00)
        else $error("Inactive data line driven.");
    buf_room_a: assert property (
        rd_q |-> cnt_q != 2'h2 ##1 !rd_q)
        else $error("Fetch issued into a full buffer.");
    end_count_a: assert property (
        st_q == PCL_CHECK |=> bits_q == {$past(sel_len), 2'h0})
        else $error("Bit count not loaded from length.");
endmodule
`default_nettype wire

// ===== pcl_target_model.sv
// Model of the target devices fed by the loader's data lines.
// Assumes data changes on the falling dclk edge and is stable at the rise.
`timescale 1ns/1ps
`default_nettype none
module pcl_target_model
(
    input wire logic dclk,
    input wire logic [pcl_pkg::PCL_LINES-1:0] data,
    input wire logic data_en,
    input wire logic reconfig_n,
    output logic load_complete,
    output logic error_line_n
);
    // Every group seen on all lines, lowest line in bit 0.
    logic [pcl_pkg::PCL_LINES-1:0] groups[$];
    // The targets never report a fault in these runs.
    initial
    begin
        load_complete = 1'b0;
        error_line_n = 1'b1;
    end
    // All lines are kept, since any line may feed a whole chain.
    always @(posedge dclk)
    begin
        if (data_en === 1'b1)
            groups.push_back(data);
    end
    // A reconfiguration request clears every target.
    always @(negedge reconfig_n)
    begin
        load_complete = 1'b0;
        groups.delete();
    end
    // The chain reports completion once the stream stops.
    always @(negedge data_en)
        load_complete = (groups.size() != 0);
endmodule
`default_nettype wire

// ===== tb_top.sv
// Self-checking bench for the paged configuration loader.
// Assumes a zero-wait register slave and one flash answer per read.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import pcl_pkg::*;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata, q;
    logic [1:0] htrans;
    logic [2:0] hsize, page_select_inputs;
    logic flash_rd, flash_rvalid, target_dclk, target_data_en;
    logic [22:0] flash_addr, fa;
    logic [15:0] flash_rdata;
    logic [7:0] target_data;
    logic target_reconfig_request_n, target_load_complete;
    logic target_error_line_n;
    int fails, check_count, seed;
    pcl_paged_config_loader i_dut (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
        .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .page_select_inputs(page_select_inputs), .flash_rd(flash_rd),
        .flash_addr(flash_addr), .flash_rdata(flash_rdata),
        .flash_rvalid(flash_rvalid), .target_dclk(target_dclk),
        .target_data(target_data), .target_data_en(target_data_en),
        .target_reconfig_request_n(target_reconfig_request_n),
        .target_load_complete(target_load_complete),
        .target_error_line_n(target_error_line_n));
    pcl_target_model tgt (.dclk(target_dclk), .data(target_data),
        .data_en(target_data_en), .reconfig_n(target_reconfig_request_n),
        .load_complete(target_load_complete),
        .error_line_n(target_error_line_n));
    // Free-running 250 MHz clock.
    always #2 hclk = ~hclk;
    // Flash content derived from the word address only.
    function automatic logic [15:0] fword(input logic [22:0] a);
        return {a[7:0], a[15:8]} ^ 16'h5ac3;
    endfunction
    // Flash answers each read after a random delay, then garbles its bus.
    initial
    begin
        forever
        begin
            @(negedge hclk);
            if (flash_rd === 1'b1)
            begin
                fa = flash_addr;
                repeat (1 + {$random(seed)} % 4) @(posedge hclk);
                flash_rvalid <= 1'b1;
                flash_rdata <= fword(fa);
                @(posedge hclk);
                flash_rvalid <= 1'b0;
                flash_rdata <= ~fword(fa);
            end
        end
    end
    task automatic summarize;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp,
        input string what);
        check_count++;
        if (got !== exp)
        begin
            fails++;
            $display("CHECK FAILED %0t %s: %h not %h", $time, what, got, exp);
        end
    endtask
    // Waits for hready at an edge; running out of patience ends the run.
    task automatic ready_edge;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1 && n < 50)
        begin
            @(posedge hclk);
            n++;
        end
        if (n >= 50)
        begin
            fails++;
            summarize();
        end
    endtask
    // One single word transfer: address phase, then data phase.
    task automatic bus(input logic w, input logic [31:0] a,
        input logic [31:0] d, output logic [31:0] r);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        hsize <= 3'h2;
        haddr <= a;
        ready_edge();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        ready_edge();
        r = hrdata;
        chk({31'h0, hresp}, 32'h0, "bus response");
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] r;
        bus(1'b1, a, d, r);
    endtask
    task automatic rd(input logic [31:0] a, output logic [31:0] r);
        bus(1'b0, a, 32'h0, r);
    endtask
    task automatic do_reset;
        hresetn <= 1'b0;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
    endtask
    // Polls the status word until the loader settles in done or error.
    task automatic wait_end(output logic [31:0] s);
        int n;
        n = 0;
        s = 32'h0;
        while (s[2:0] !== 3'h4 && s[2:0] !== 3'h5 && n < 3000)
        begin
            rd({20'h0, PCL_OFF_STATUS}, s);
            n++;
        end
        if (n >= 3000)
        begin
            fails++;
            summarize();
        end
    endtask
    // Loads one page and compares every group with the reference stream.
    task automatic run(input int pg, input logic [22:0] st, input int len,
        input int mode);
        logic [31:0] s;
        logic [15:0] wd;
        logic [7:0] e;
        int w, ng, i;
        w = 1 << mode;
        ng = len * 4 / w;
        wr(32'h40 + 8 * pg, {9'h0, st});
        wr(32'h44 + 8 * pg, len);
        page_select_inputs <= pg[2:0];
        repeat (6) @(posedge hclk);
        wr(32'h0, {29'h0, mode[1:0], 1'b1});
        repeat (20) @(posedge hclk);
        // Moving the pins mid-load must not disturb the chosen page.
        page_select_inputs <= ~pg[2:0];
        wait_end(s);
        repeat (10) @(posedge hclk);
        rd({20'h0, PCL_OFF_STATUS}, s);
        chk(s, 32'h614 | (pg << 6), "status after load");
        chk(tgt.groups.size(), ng, "group count");
        for (int g = 0; g < ng; g++)
        begin
            e = 8'h0;
            for (int j = 0; j < w; j++)
            begin
                i = g * w + j;
                wd = fword(23'(st + i / 16));
                e[j] = wd[i % 16];
            end
            chk(tgt.groups[g], e, "data group");
        end
        $display("load of page %0d mode %0d finished", pg, mode);
    endtask
    // Starts a load that must end in the error state without data.
    task automatic go_err(input int pg);
        logic [31:0] s;
        page_select_inputs <= pg[2:0];
        repeat (6) @(posedge hclk);
        wr(32'h0, 32'h1);
        repeat (20) @(posedge hclk);
        wait_end(s);
        chk(s, 32'h20d | (pg << 6), "error status");
        chk(tgt.groups.size(), 0, "no data in error");
        $display("error case on page %0d finished", pg);
    endtask
    initial
    begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hsize = 3'h2;
        hwdata = 32'h0;
        page_select_inputs = 3'h0;
        flash_rvalid = 1'b0;
        flash_rdata = 16'h0;
        fails = 0;
        check_count = 0;
        seed = 32'h9a90;
        do_reset();
        for (int p = 0; p < PCL_PAGES; p++)
        begin
            rd(32'h40 + 8 * p, q);
            chk(q, 32'h0, "start reset");
            rd(32'h44 + 8 * p, q);
            chk(q, 32'h0, "length reset");
        end
        wr(32'h0fc, 32'hffffffff);
        rd(32'h0fc, q);
        chk(q, 32'h0, "unmapped read");
        $display("register reset test finished");
        run(0, PCL_PAGE_MIN, 2, 0);
        for (int m = 0; m < 4; m++)
            run({$random(seed)} % 8, PCL_PAGE_MIN + {$random(seed)} % 4096,
                2 * (1 + {$random(seed)} % 6), m);
        run(7, PCL_PAGE_MAX, 4, 3);
        wr(32'h68, {9'h0, PCL_PAGE_MIN - 23'h1});
        wr(32'h6c, 32'h4);
        go_err(5);
        go_err(5);
        do_reset();
        go_err(6);
        do_reset();
        run(6, 23'h010000, 6, 1);
        summarize();
    end
endmodule
`default_nettype wire
